// [hdl/clock_speed_pkg.sv]
// Package: register map, field layout and speed constants of the clock speed selector
package clock_speed_pkg;
    localparam logic [11:0] control_reg_offset = 12'h000;
    localparam logic [11:0] periph_reg_offset = 12'h004;
    localparam logic [11:0] status_reg_offset = 12'h008;
    localparam int double_speed_bit = 0;
    localparam int timer0_bit = 1;
    localparam int timer1_bit = 2;
    localparam int timer2_bit = 3;
    localparam int uart_bit = 4;
    localparam int pca_bit = 5;
    localparam int watchdog_bit = 6;
    localparam int can_bit = 7;
    localparam int spi_bit = 0;
    localparam int num_periph = 8;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [0:0] periph_reset = 1'h0;
    localparam int standard_periods = 12;
    localparam int double_periods = 6;
    localparam int phase_count_width = 4;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;
endpackage

// [hdl/double_speed_clock_select.sv]
// Clock speed selector: halving stage, double speed switch, per-peripheral select
`timescale 1ns/1ns
`default_nettype none
module double_speed_clock_select #(
    parameter int num_periph = clock_speed_pkg::num_periph
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Oscillator sample and nonvolatile start option
    input wire logic crystal_input,
    input wire logic reset_double_speed_option,
    // APB slave
    input wire clock_speed_pkg::apb_req_s apb_req,
    output clock_speed_pkg::apb_rsp_s apb_rsp,
    // Clock enables towards the core and peripherals, and the speed mode flags
    output logic cpu_cycle_strobe,
    output logic [num_periph-1:0] periph_cycle_strobe,
    output logic double_speed_mode,
    output logic standard_speed_mode
);
    typedef enum logic [3:0] {
        st_reset = 4'b0001,
        st_settle = 4'b0010,
        st_capture = 4'b0100,
        st_run = 4'b1000
    } boot_e;

    typedef struct packed {
        boot_e boot;
        logic [1:0] xin_sync;
        logic [1:0] opt_sync;
        logic xin_prev;
        logic half_clk;
        logic [7:0] control;
        logic spi_select;
        logic active_fast;
    } state_s;

    state_s st;
    state_s next_st;
    logic xtal_rise;
    logic half_rise;
    logic cpu_strobe;
    logic [num_periph-1:0] periph_fast;
    logic [num_periph-1:0] periph_slow;
    logic [31:0] next_rdata;
    logic apb_write;

    // The crystal is sampled on sys_clk; each rising crystal edge is one oscillator period
    assign xtal_rise = st.xin_sync[1] & ~st.xin_prev;
    // Halved clock rises on every second crystal rising edge
    assign half_rise = xtal_rise & ~st.half_clk;
    assign apb_write = apb_req.psel & apb_req.penable & apb_req.pwrite;

    always_comb begin
        next_st = st;
        next_st.xin_sync = {st.xin_sync[0], crystal_input};
        next_st.opt_sync = {st.opt_sync[0], reset_double_speed_option};
        next_st.xin_prev = st.xin_sync[1];
        if (xtal_rise) begin
            next_st.half_clk = ~st.half_clk;
        end
        case (st.boot)
            st_reset: begin
                next_st.boot = st_settle;
            end
            // One extra cycle lets the strap pass both synchroniser stages
            st_settle: begin
                next_st.boot = st_capture;
            end
            st_capture: begin
                // Option is a strap, caught after reset release, not by the reset itself
                next_st.control[clock_speed_pkg::double_speed_bit] =
                    st.opt_sync[1];
                next_st.active_fast = st.opt_sync[1];
                next_st.boot = st_run;
            end
            st_run: begin
                if (apb_write && apb_req.paddr == clock_speed_pkg::control_reg_offset) begin
                    next_st.control = apb_req.pwdata[7:0];
                end
                if (apb_write && apb_req.paddr == clock_speed_pkg::periph_reg_offset) begin
                    next_st.spi_select = apb_req.pwdata[clock_speed_pkg::spi_bit];
                end
                // Both directions wait for a halved clock rise, so no short cycle leaks out
                if (half_rise) begin
                    next_st.active_fast =
                        st.control[clock_speed_pkg::double_speed_bit];
                end
            end
            default: begin
                next_st.boot = st_reset;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st.boot <= st_reset;
            st.xin_sync <= 2'h0;
            st.opt_sync <= 2'h0;
            st.xin_prev <= 1'b0;
            st.half_clk <= 1'b0;
            st.control <= clock_speed_pkg::control_reset;
            st.spi_select <= clock_speed_pkg::periph_reset;
            st.active_fast <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Core phase generator: full crystal in double speed, halved otherwise
    speed_phase_gen #(
        .standard_periods(clock_speed_pkg::standard_periods),
        .double_periods(clock_speed_pkg::double_periods)
    ) cpu_phase (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .tick_full(xtal_rise),
        .tick_half(half_rise),
        .fast(st.active_fast),
        .cycle_strobe(cpu_strobe)
    );

    // Peripheral select bits count only once the CPU runs fast
    assign periph_slow = num_periph'({st.spi_select,
        st.control[clock_speed_pkg::can_bit:clock_speed_pkg::timer0_bit]});

    // Each peripheral has its own phase counter; the CPU bit alone, with its select bit clear, runs it fast
    genvar gi;
    generate
        for (gi = 0; gi < num_periph; gi = gi + 1) begin : g_periph
            assign periph_fast[gi] = st.active_fast & ~periph_slow[gi];
            speed_phase_gen #(
                .standard_periods(clock_speed_pkg::standard_periods),
                .double_periods(clock_speed_pkg::double_periods)
            ) periph_phase (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .tick_full(xtal_rise),
                .tick_half(half_rise),
                .fast(periph_fast[gi]),
                .cycle_strobe(periph_cycle_strobe[gi])
            );
        end
    endgenerate

    assign cpu_cycle_strobe = cpu_strobe;
    assign double_speed_mode = st.active_fast;
    assign standard_speed_mode = ~st.active_fast;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (apb_req.paddr)
            clock_speed_pkg::control_reg_offset: next_rdata[7:0] = st.control;
            clock_speed_pkg::periph_reg_offset: next_rdata[0] = st.spi_select;
            clock_speed_pkg::status_reg_offset: next_rdata[0] = st.active_fast;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_comb begin
        apb_rsp.prdata = next_rdata;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable &
            (apb_req.paddr != clock_speed_pkg::control_reg_offset) &
            (apb_req.paddr != clock_speed_pkg::periph_reg_offset) &
            (apb_req.paddr != clock_speed_pkg::status_reg_offset);
    end
endmodule
`default_nettype wire

// [hdl/speed_phase_gen.sv]
// Machine cycle phase generator: one strobe every N enabled ticks
`timescale 1ns/1ns
`default_nettype none
module speed_phase_gen #(
    parameter int standard_periods = clock_speed_pkg::standard_periods,
    parameter int double_periods = clock_speed_pkg::double_periods
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Clock source ticks and selected mode
    input wire logic tick_full,
    input wire logic tick_half,
    input wire logic fast,
    // Cycle strobe
    output logic cycle_strobe
);
    localparam logic [3:0] last_std = 4'(standard_periods / 2 - 1);
    localparam logic [3:0] last_dbl = 4'(double_periods - 1);

    typedef struct packed {
        logic [3:0] count;
        logic strobe;
    } state_s;

    state_s st;
    state_s next_st;
    logic tick;

    // In standard mode the halved clock counts, so 6 halved ticks give 12 periods
    assign tick = fast ? tick_full : tick_half;

    always_comb begin
        next_st = st;
        next_st.strobe = 1'b0;
        if (tick) begin
            if (st.count >= (fast ? last_dbl : last_std)) begin
                next_st.count = 4'h0;
                next_st.strobe = 1'b1;
            end else begin
                next_st.count = st.count + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cycle_strobe = st.strobe;
endmodule
`default_nettype wire

// [test/crystal_source.sv]
// Free-running crystal oscillator model for the clock speed selector
`timescale 1ns/1ns
`default_nettype none
module crystal_source #(
    parameter int half_cycles = 4
) (
    // Reference clock
    input wire logic sys_clk,
    // Oscillator level
    output var logic crystal_input
);
    int cnt = 0;
    initial crystal_input = 1'b0;
    // Stepped from the system clock so every period is exact and measurable
    always @(posedge sys_clk) begin
        cnt <= (cnt == half_cycles - 1) ? 0 : cnt + 1;
        if (cnt == half_cycles - 1) begin
            crystal_input <= !crystal_input;
        end
    end
endmodule
`default_nettype wire

// [test/double_speed_clock_select_assertions.sv]
// Port assertions for the clock speed selector
`timescale 1ns/1ns
`default_nettype none
module double_speed_clock_select_assertions #(
    parameter int num_periph = 8
) (
    // Clock and inputs
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic crystal_input,
    input wire logic reset_double_speed_option,
    input wire clock_speed_pkg::apb_req_s apb_req,
    // Outputs
    input wire clock_speed_pkg::apb_rsp_s apb_rsp,
    input wire logic cpu_cycle_strobe,
    input wire logic [num_periph-1:0] periph_cycle_strobe,
    input wire logic double_speed_mode,
    input wire logic standard_speed_mode
);
    logic xq;
    logic [3:0] age;
    // Cycles since the last crystal rise, saturating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            xq <= 1'b0;
            age <= 4'hf;
        end else begin
            xq <= crystal_input;
            age <= (crystal_input && !xq) ? 4'h0 : age + {3'h0, age != 4'hf};
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Gap figures assume the bench oscillator of eight system clocks per period
    AST_MODE_PAIR: assert property (standard_speed_mode == !double_speed_mode)
        else $error("mode outputs disagree");
    AST_RESET_STD: assert property (!$past(nrst) |-> !double_speed_mode)
        else $error("not standard after reset");
    AST_STRAP: assert property ($past(nrst) && !$past(nrst, 2) |=> ##1
        double_speed_mode == reset_double_speed_option) else $error("strap not loaded");
    AST_PULSE: assert property (cpu_cycle_strobe |=> !cpu_cycle_strobe)
        else $error("strobe too wide");
    AST_STD_GAP: assert property ((cpu_cycle_strobe && !double_speed_mode) ##96
        !double_speed_mode |-> cpu_cycle_strobe) else $error("standard cycle wrong");
    AST_DBL_GAP: assert property ((cpu_cycle_strobe && double_speed_mode) ##48
        double_speed_mode |-> cpu_cycle_strobe) else $error("double cycle wrong");
    AST_ALIGN: assert property ($changed(double_speed_mode) && $past(nrst, 4)
        |-> age <= 4'h6) else $error("mode change off halved edge");
    AST_STROBE_EDGE: assert property (cpu_cycle_strobe |-> age <= 4'h6)
        else $error("strobe not tied to crystal");
    AST_UNMAPPED: assert property (apb_req.psel && apb_req.penable &&
        apb_req.paddr > 12'h008 |-> apb_rsp.pslverr) else $error("no slave error");
    cover property ($rose(double_speed_mode));
    cover property ($fell(double_speed_mode));
    cover property (double_speed_mode && periph_cycle_strobe[0]);
endmodule
bind double_speed_clock_select double_speed_clock_select_assertions #(
    .num_periph(num_periph)) chk (.*);
`default_nettype wire

// [test/double_speed_clock_select_tb_top.sv]
// Self-checking testbench for the clock speed selector
`timescale 1ns/1ns
`default_nettype none
module double_speed_clock_select_tb_top;
    localparam int xh = 4;
    localparam int std_gap = clock_speed_pkg::standard_periods * 2 * xh;
    localparam int dbl_gap = clock_speed_pkg::double_periods * 2 * xh;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic option = 1'b0;
    logic xtal;
    clock_speed_pkg::apb_req_s req = '0;
    clock_speed_pkg::apb_rsp_s rsp;
    logic cpu_s;
    logic [7:0] ps;
    logic dsm;
    logic ssm;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    always #10 sys_clk = !sys_clk;
    crystal_source #(.half_cycles(xh)) osc (.sys_clk(sys_clk), .crystal_input(xtal));
    double_speed_clock_select uut (.sys_clk(sys_clk), .nrst(nrst), .crystal_input(xtal),
        .reset_double_speed_option(option), .apb_req(req), .apb_rsp(rsp),
        .cpu_cycle_strobe(cpu_s), .periph_cycle_strobe(ps), .double_speed_mode(dsm),
        .standard_speed_mode(ssm));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // Answer and data are taken at the edge where pready is seen high
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Skips the first two strobe waits, in which a mode change may land, then measures the third
    task gap(input int idx);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
            end while ((idx < 0 ? cpu_s : ps[idx]) !== 1'b1 && n < 300);
        end
    endtask
    task do_reset(input logic opt);
        @(posedge sys_clk);
        nrst <= 1'b0;
        option <= opt;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    task t_standard();
        do_reset(1'b0);
        @(negedge sys_clk);
        chk(ssm, 1'b1);
        apb(1'b1, 12'h000, 32'h0000_0000);
        gap(-1);
        chk(n, std_gap);
        gap(0);
        chk(n, std_gap);
        $display("standard test done");
    endtask
    task t_double();
        apb(1'b1, 12'h000, 32'h0000_0001);
        gap(-1);
        chk(n, dbl_gap);
        chk(dsm, 1'b1);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 12'h000, 32'h1 | (32'h2 << i));
            gap(i);
            chk(n, std_gap);
            gap(i + 1);
            chk(n, dbl_gap);
        end
        apb(1'b1, 12'h004, 32'h0000_0001);
        gap(7);
        chk(n, std_gap);
        gap(-1);
        chk(n, dbl_gap);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        gap(-1);
        chk(n, std_gap);
        gap(0);
        chk(n, std_gap);
        $display("double test done");
    endtask
    task t_unmapped();
        apb(1'b1, 12'h00c, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        $display("unmapped test done");
    endtask
    task t_strap();
        do_reset(1'b1);
        @(negedge sys_clk);
        chk(dsm, 1'b1);
        gap(-1);
        chk(n, dbl_gap);
        $display("strap test done");
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        t_standard();
        t_double();
        t_unmapped();
        t_strap();
        give_verdict();
    end
endmodule
`default_nettype wire
